// ==== design/cam_defines.svh ====
/*
 * Register offsets, reset values, field positions and timing figures of the
 * cam output controller.
 * Assumes a 250 MHz aclk and byte addresses on a 32-bit AXI4-Lite bus.
 */
`ifndef CAM_DEFINES_SVH
`define CAM_DEFINES_SVH

`define CAM_CLK_MHZ 250
`define CAM_SPEED_WIN_US 1000
`define CAM_SPEED_WIN_CYC (`CAM_SPEED_WIN_US * `CAM_CLK_MHZ)
`define CAM_TIMER_UNIT_NS 1000
`define CAM_TIMER_UNIT_CYC ((`CAM_TIMER_UNIT_NS * `CAM_CLK_MHZ) / 1000)

`define CAM_RAW_W 12
`define CAM_FRAC_SHIFT 8
`define CAM_GRAY_W 8
`define CAM_ANA_FULL 16'hFFFF

`define CAM_REG_CTRL 8'h00
`define CAM_REG_SCALE 8'h04
`define CAM_REG_PROG 8'h08
`define CAM_REG_SEL 8'h0C
`define CAM_REG_ON 8'h10
`define CAM_REG_OFF 8'h14
`define CAM_REG_CHCFG 8'h18
`define CAM_REG_TIMED 8'h1C
`define CAM_REG_SPD_LO 8'h20
`define CAM_REG_SPD_HI 8'h24
`define CAM_REG_COMP 8'h28
`define CAM_REG_GRPMODE 8'h2C
`define CAM_REG_ANA_ZERO 8'h30
`define CAM_REG_ANA_FULL 8'h34
`define CAM_REG_MARK 8'h38
`define CAM_REG_POS 8'h3C
`define CAM_REG_SPEED 8'h40
`define CAM_REG_IRQ_STAT 8'h44
`define CAM_REG_IRQ_EN 8'h48
`define CAM_REG_IRQ_CLR 8'h4C
`define CAM_REG_OUTS 8'h50

`define CAM_SCALE_RST 16'h0168
`define CAM_SPD_HI_RST 16'hFFFF
`define CAM_CTRL_GRAY_BIT 0
`define CAM_POS_DIR_BIT 31
`define CAM_MARK_HI_LSB 16
`define CAM_COMP_TRAIL_LSB 16
`define CAM_SEL_PROG_LSB 8
`define CAM_GRP_MODE_W 3
`define CAM_IRQ_W 3

`define CAM_RESP_OKAY 2'b00
`define CAM_RESP_SLVERR 2'b10

`endif

// ==== design/cam_pkg.sv ====
/*
 * Types shared by the cam output controller and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cam_pkg;

   typedef enum logic [1:0] {
      DIR_ANY = 2'b00,
      DIR_FWD = 2'b01,
      DIR_REV = 2'b11
   } dir_mode_t;

   typedef enum logic [2:0] {
      GM_ALWAYS = 3'b000,
      GM_LEVEL = 3'b001,
      GM_ARM_REV = 3'b011,
      GM_ARM_HOLD = 3'b010,
      GM_INVERT = 3'b110
   } grp_mode_t;

   // Per-output configuration word, high bits first in the register.
   typedef struct packed {
      logic [1:0] group;
      dir_mode_t dir_mode;
      logic comp;
      logic motion;
      logic timed;
   } ch_cfg_t;

   typedef struct packed {
      logic motion_change;
      logic late;
      logic early;
   } irq_t;

endpackage

// ==== design/cam_output_controller.sv ====
/*
 * Electronic cam switch: compares the scaled shaft position with per-output
 * on/off setpoints of the active program and drives the cam outputs.
 * Assumes a transducer giving a raw 12-bit angle that moves at most half a
 * turn between clock edges, asynchronous pins, and an AXI4-Lite master.
 */
// How it works
// - Output on from on position to off position, same every revolution.
// - Timed output turns on at on position, off after programmed duration.
// - Timed output still turns off at off position if not yet expired.
// - Motion-qualified outputs forced off when speed outside low/high window.
// - Speed compensation moves switching points earlier as speed rises.
// - Increments per revolution programmable, up to 1024, or 4096 high-res.
// - Scale of 360 makes positions and setpoints whole degrees.
// - Gray option puts eight gray-coded position bits on last eight outputs.
// - Outputs ignore direction by default, optionally qualified by direction.
// - Turn-on and turn-off edges get separate compensation amounts.
// - Output groups tied to enable inputs, five modes, some need product.
// - Setpoint store holds up to 64 programs, 256 with large memory.
// - Changing active program switches all setpoints at once, several sources.
// - Analog level linear in speed, programmable zero level and full speed.
// - Product mark judged early or late against a position window.
`include "cam_defines.svh"

module cam_output_controller import cam_pkg::*; #(
   parameter int N_OUT = 16,
   parameter int N_PROG = 64,
   parameter int MAX_SCALE = 1024,
   parameter int SPEED_WIN_CYC = `CAM_SPEED_WIN_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`CAM_RAW_W-1:0] raw_pos,
   input wire logic [2:0] prog_sel,
   input wire logic [3:0] group_en,
   input wire logic mark_in,
   output logic [N_OUT-1:0] cam_out,
   output logic motion_ok,
   output logic [15:0] analog_level,
   output logic irq
);
   localparam int RW = `CAM_RAW_W;
   localparam int PW = $clog2(N_PROG);
   localparam int CW = $clog2(N_OUT);
   localparam int SW = RW + 3 + 4 + 1;

   initial
   begin
      if (N_OUT < `CAM_GRAY_W || N_OUT > 64 || N_PROG < 8 || N_PROG > 256 ||
          !(MAX_SCALE == 1024 || MAX_SCALE == 4096) || SPEED_WIN_CYC < 2)
         $error("cam_output_controller: unsupported parameters");
   end

   // Pins pass two flip-flops; only the second stage is read.
   logic [SW-1:0] sync1, sync2;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {raw_pos, prog_sel, group_en, mark_in};
         sync2 <= sync1;
      end
   end
   logic [RW-1:0] raw;
   logic [2:0] sel_pins;
   logic [3:0] grp_in;
   logic mark_s;
   assign {raw, sel_pins, grp_in, mark_s} = sync2;

   // Software-visible state.
   logic gray_en;
   logic [RW:0] scale;
   logic [PW-1:0] kbd_prog;
   logic [PW-1:0] sel_prog;
   logic [CW-1:0] sel_ch;
   logic [15:0] timed_dur, spd_lo, spd_hi, lead_k, trail_k, ana_zero, ana_full;
   logic [15:0] mark_lo, mark_hi;
   logic [3*`CAM_GRP_MODE_W-1+`CAM_GRP_MODE_W:0] grp_mode_r;
   irq_t irq_stat, irq_en, irq_set, irq_clr;
   logic [2*RW-1:0] sp_mem [N_PROG*N_OUT];
   ch_cfg_t ch_cfg [N_OUT];

   // Position, direction and speed measurement.
   logic [RW-1:0] raw_prev, pos, pos_prev;
   logic [2*RW:0] pos_prod;
   logic [RW-1:0] delta, step;
   logic fwd, moving;
   logic [15:0] speed, acc;
   logic [31:0] win_cnt;
   assign pos_prod = (2*RW+1)'(raw) * (2*RW+1)'(scale);
   assign delta = raw - raw_prev;
   assign moving = delta != '0;
   assign step = delta[RW-1] ? RW'(-delta) : delta;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         raw_prev <= '0;
         pos <= '0;
         pos_prev <= '0;
         fwd <= 1'b1;
      end
      else
      begin
         raw_prev <= raw;
         pos <= pos_prod[2*RW-1:RW];
         pos_prev <= pos;
         if (moving)
            fwd <= !delta[RW-1];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc <= '0;
         speed <= '0;
         win_cnt <= '0;
      end
      else if (win_cnt == 32'(SPEED_WIN_CYC - 1))
      begin
         win_cnt <= '0;
         speed <= acc + 16'(step);
         acc <= '0;
      end
      else
      begin
         win_cnt <= win_cnt + 32'd1;
         acc <= acc + 16'(step);
      end
   end

   logic wrapped;
   assign wrapped = fwd ? pos < pos_prev : pos > pos_prev;

   logic next_motion_ok;
   assign next_motion_ok = speed >= spd_lo && speed <= spd_hi;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         motion_ok <= 1'b0;
      else
         motion_ok <= next_motion_ok;
   end

   // nonzero pins take priority over the keyboard program; pins at zero select it
   logic [PW-1:0] act_prog;
   assign act_prog = sel_pins != 3'd0 ? PW'(sel_pins) : kbd_prog;

   // separate lead and trail advance, clamped below one revolution
   function automatic logic [RW-1:0] advance(input logic [15:0] k, input logic [15:0] spd,
                                             input logic [RW:0] sc);
      logic [31:0] a;
      a = (32'(spd) * 32'(k)) >> `CAM_FRAC_SHIFT;
      advance = a >= 32'(sc) ? RW'(sc - 1'b1) : RW'(a);
   endfunction
   function automatic logic [RW-1:0] back(input logic [RW-1:0] p, input logic [RW-1:0] a,
                                          input logic [RW:0] sc);
      back = p >= a ? p - a : RW'((RW+1)'(p) + sc - (RW+1)'(a));
   endfunction
   logic [RW-1:0] adv_on, adv_off;
   assign adv_on = advance(lead_k, speed, scale);
   assign adv_off = advance(trail_k, speed, scale);

   logic [3:0] armed, grp_ok, grp_prev;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         armed <= '0;
         grp_prev <= '0;
      end
      else
      begin
         grp_prev <= grp_in;
         for (int g = 0; g < 4; g++)
         begin
            if (grp_in[g] && !grp_prev[g])
               armed[g] <= 1'b1;
            else if (wrapped && grp_mode_t'(grp_mode_r[g*`CAM_GRP_MODE_W +: `CAM_GRP_MODE_W]) == GM_ARM_REV)
               armed[g] <= 1'b0;
         end
      end
   end
   always_comb
   begin
      for (int g = 0; g < 4; g++)
      begin
         case (grp_mode_t'(grp_mode_r[g*`CAM_GRP_MODE_W +: `CAM_GRP_MODE_W]))
            GM_ALWAYS: grp_ok[g] = 1'b1;
            GM_LEVEL: grp_ok[g] = grp_in[g];
            GM_ARM_REV: grp_ok[g] = armed[g];
            GM_ARM_HOLD: grp_ok[g] = armed[g] && grp_in[g];
            GM_INVERT: grp_ok[g] = !grp_in[g];
            default: grp_ok[g] = 1'b1;
         endcase
      end
   end

   logic [N_OUT-1:0] cam_bits;
   for (genvar c = 0; c < N_OUT; c++)
   begin : g_ch
      logic [RW-1:0] on_p, off_p;
      logic in_win, win_prev, dir_ok;
      logic [31:0] timer;
      ch_cfg_t cfg;
      assign cfg = ch_cfg[c];
      assign {off_p, on_p} = sp_mem[{act_prog, CW'(c)}];
      logic [RW-1:0] eff_on, eff_off;
      assign eff_on = cfg.comp ? back(on_p, adv_on, scale) : on_p;
      assign eff_off = cfg.comp ? back(off_p, adv_off, scale) : off_p;
      assign in_win = eff_on <= eff_off ? (pos >= eff_on && pos < eff_off)
                                        : (pos >= eff_on || pos < eff_off);
      assign dir_ok = cfg.dir_mode == DIR_ANY || (cfg.dir_mode == DIR_FWD) == fwd;
      // timer loads at the on edge
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            win_prev <= 1'b0;
            timer <= '0;
         end
         else
         begin
            win_prev <= in_win;
            if (in_win && !win_prev)
               timer <= 32'(timed_dur) * 32'(`CAM_TIMER_UNIT_CYC);
            else if (timer != '0)
               timer <= timer - 32'd1;
         end
      end
      // timed output is also bounded by the window
      assign cam_bits[c] = in_win && dir_ok && grp_ok[cfg.group] &&
                           (!cfg.timed || timer != '0 || !win_prev) &&
                           (!cfg.motion || motion_ok);
   end

   // gray position on the last eight outputs
   logic [`CAM_GRAY_W-1:0] gray;
   logic [N_OUT-1:0] next_out;
   assign gray = pos[`CAM_GRAY_W-1:0] ^ (pos[`CAM_GRAY_W-1:0] >> 1);
   always_comb
   begin
      next_out = cam_bits;
      if (gray_en)
         next_out[N_OUT-1 -: `CAM_GRAY_W] = gray;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cam_out <= '0;
      else
         cam_out <= next_out;
   end

   logic [31:0] ana_span;
   assign ana_span = 32'(`CAM_ANA_FULL - ana_zero) * 32'(speed);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         analog_level <= '0;
      else if (ana_full == '0 || speed >= ana_full)
         analog_level <= `CAM_ANA_FULL;
      else
         analog_level <= ana_zero + 16'(ana_span / 32'(ana_full));
   end

   logic mark_prev;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mark_prev <= 1'b0;
      else
         mark_prev <= mark_s;
   end
   assign irq_set.early = mark_s && !mark_prev && 16'(pos) < mark_lo;
   assign irq_set.late = mark_s && !mark_prev && 16'(pos) > mark_hi;
   assign irq_set.motion_change = motion_ok != next_motion_ok;

   // AXI4-Lite slave: address and data are caught in either order.
   logic aw_full, w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic do_write;
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign irq_clr = do_write && aw_addr == `CAM_REG_IRQ_CLR ? irq_t'(w_data[`CAM_IRQ_W-1:0]) : '0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CAM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (do_write)
         begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_addr > `CAM_REG_OUTS || aw_addr[1:0] != 2'b00 ? `CAM_RESP_SLVERR : `CAM_RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Byte strobes are ignored: every register takes a full word write.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gray_en <= 1'b0;
         scale <= (RW+1)'(`CAM_SCALE_RST);
         kbd_prog <= '0;
         sel_prog <= '0;
         sel_ch <= '0;
         timed_dur <= '0;
         spd_lo <= '0;
         spd_hi <= `CAM_SPD_HI_RST;
         lead_k <= '0;
         trail_k <= '0;
         grp_mode_r <= '0;
         ana_zero <= '0;
         ana_full <= '0;
         mark_lo <= '0;
         mark_hi <= '0;
         irq_en <= '0;
      end
      else if (do_write)
      begin
         case (aw_addr)
            `CAM_REG_CTRL: gray_en <= w_data[`CAM_CTRL_GRAY_BIT];
            `CAM_REG_SCALE:
               if (w_data != '0 && w_data <= 32'(MAX_SCALE))
                  scale <= (RW+1)'(w_data);
            `CAM_REG_PROG: kbd_prog <= PW'(w_data);
            `CAM_REG_SEL:
            begin
               sel_ch <= CW'(w_data);
               sel_prog <= PW'(w_data >> `CAM_SEL_PROG_LSB);
            end
            `CAM_REG_TIMED: timed_dur <= w_data[15:0];
            `CAM_REG_SPD_LO: spd_lo <= w_data[15:0];
            `CAM_REG_SPD_HI: spd_hi <= w_data[15:0];
            `CAM_REG_COMP: {trail_k, lead_k} <= w_data;
            `CAM_REG_GRPMODE: grp_mode_r <= w_data[$bits(grp_mode_r)-1:0];
            `CAM_REG_ANA_ZERO: ana_zero <= w_data[15:0];
            `CAM_REG_ANA_FULL: ana_full <= w_data[15:0];
            `CAM_REG_MARK: {mark_hi, mark_lo} <= w_data;
            `CAM_REG_IRQ_EN: irq_en <= irq_t'(w_data[`CAM_IRQ_W-1:0]);
            default: ;
         endcase
      end
   end

   // setpoint store, one on/off pair per output per program
   always_ff @(posedge aclk)
   begin
      if (do_write && aw_addr == `CAM_REG_ON)
         sp_mem[{sel_prog, sel_ch}][RW-1:0] <= w_data[RW-1:0];
      if (do_write && aw_addr == `CAM_REG_OFF)
         sp_mem[{sel_prog, sel_ch}][2*RW-1:RW] <= w_data[RW-1:0];
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int c = 0; c < N_OUT; c++)
            ch_cfg[c] <= '0;
      end
      else if (do_write && aw_addr == `CAM_REG_CHCFG)
         ch_cfg[sel_ch] <= ch_cfg_t'(w_data[$bits(ch_cfg_t)-1:0]);
   end

   // Hardware sets win over a same-cycle software clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat <= '0;
      else
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
   end
   assign irq = |(irq_stat & irq_en);

   logic [31:0] rd;
   always_comb
   begin
      case (s_axi_araddr[7:0])
         `CAM_REG_CTRL: rd = 32'(gray_en);
         `CAM_REG_SCALE: rd = 32'(scale);
         `CAM_REG_PROG: rd = 32'(act_prog);
         `CAM_REG_SEL: rd = (32'(sel_prog) << `CAM_SEL_PROG_LSB) | 32'(sel_ch);
         `CAM_REG_ON: rd = 32'(sp_mem[{sel_prog, sel_ch}][RW-1:0]);
         `CAM_REG_OFF: rd = 32'(sp_mem[{sel_prog, sel_ch}][2*RW-1:RW]);
         `CAM_REG_CHCFG: rd = 32'(ch_cfg[sel_ch]);
         `CAM_REG_TIMED: rd = 32'(timed_dur);
         `CAM_REG_SPD_LO: rd = 32'(spd_lo);
         `CAM_REG_SPD_HI: rd = 32'(spd_hi);
         `CAM_REG_COMP: rd = {trail_k, lead_k};
         `CAM_REG_GRPMODE: rd = 32'(grp_mode_r);
         `CAM_REG_ANA_ZERO: rd = 32'(ana_zero);
         `CAM_REG_ANA_FULL: rd = 32'(ana_full);
         `CAM_REG_MARK: rd = {mark_hi, mark_lo};
         `CAM_REG_POS: rd = (32'(fwd) << `CAM_POS_DIR_BIT) | 32'(pos);
         `CAM_REG_SPEED: rd = 32'(speed);
         `CAM_REG_IRQ_STAT: rd = 32'(irq_stat);
         `CAM_REG_IRQ_EN: rd = 32'(irq_en);
         `CAM_REG_OUTS: rd = 32'(cam_out);
         default: rd = '0;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `CAM_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd;
         s_axi_rresp <= s_axi_araddr[7:0] > `CAM_REG_OUTS || s_axi_araddr[1:0] != 2'b00 ||
                        s_axi_araddr[7:0] == `CAM_REG_IRQ_CLR ? `CAM_RESP_SLVERR : `CAM_RESP_OKAY;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// ==== dv/cam_ctrl_chk.sv ====
/*
 * Port checks for the cam output controller.
 * Assumes it is bound into cam_output_controller with a 32-bit AXI4-Lite side.
 */
module cam_ctrl_chk import cam_pkg::*; #(
   parameter int N_OUT = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [N_OUT-1:0] cam_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic wr_both;
   assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   property p_b_next;
      wr_both |-> ##2 s_axi_bvalid;
   endproperty
   a_b_next: assert property (p_b_next)
      else $error("write response late");
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand)
      else $error("write response dropped early");
   property p_r_next;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_next: assert property (p_r_next)
      else $error("read data not one cycle after the address");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand)
      else $error("read data changed early");
   property p_slverr;
      wr_both && s_axi_awaddr > 32'h0000_0050 |-> ##2 s_axi_bresp == 2'b10;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped write not refused");
   property p_outs;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000_0050 |=> s_axi_rdata == 32'($past(cam_out));
   endproperty
   a_outs: assert property (p_outs)
      else $error("output readback wrong");
   property p_irq_mask;
      wr_both && s_axi_awaddr == 32'h0000_0048 && s_axi_wdata == 32'h0 |-> ##2 !irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt up while masked");
   property p_reset;
      disable iff (1'b0) !aresetn |=> cam_out == '0 && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
endmodule

bind cam_output_controller cam_ctrl_chk #(.N_OUT(N_OUT)) chk (.*);

// ==== dv/shaft_model.sv ====
/*
 * Behavioural rotary transducer giving a raw 12-bit shaft angle.
 * Assumes its controls change just after a rising aclk edge.
 */
module shaft_model (
   input wire logic aclk,
   input wire logic load,
   input wire logic [11:0] ld_val,
   input wire logic [11:0] step,
   output logic [11:0] raw_pos
);
   timeunit 1ns;
   timeprecision 1ps;
   // The angle wraps at a full turn, so a negative step turns it backwards.
   always_ff @(posedge aclk)
   begin
      if (load)
         raw_pos <= ld_val;
      else
         raw_pos <= raw_pos + step;
   end
endmodule

// ==== dv/rotary_cam_output_controller_bench.sv ====
/*
 * Self-checking bench for the cam output controller.
 * Assumes the shaft model drives raw_pos; a full scale of 4096 makes pos equal raw.
 */
`include "cam_defines.svh"
module rotary_cam_output_controller_bench import cam_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [11:0] on, off, raw; logic exp;} row_t;
   logic aclk = 1'b0, aresetn = 1'b0, load = 1'b1, mark_in = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, motion_ok, irq;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb = 4'hf, group_en = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [11:0] raw_pos, ld_val = '0, step = '0;
   logic [2:0] prog_sel = 3'h0;
   logic [15:0] cam_out, analog_level;
   int bad_count = 0, cmp_count = 0, i;
   row_t rows [9] = '{'{12'h064, 12'h0c8, 12'h096, 1'b1}, '{12'h064, 12'h0c8, 12'h0c8, 1'b0},
      '{12'h064, 12'h0c8, 12'h064, 1'b1}, '{12'h064, 12'h0c8, 12'h063, 1'b0},
      '{12'hfa0, 12'h032, 12'hfff, 1'b1}, '{12'hfa0, 12'h032, 12'h000, 1'b1},
      '{12'hfa0, 12'h032, 12'h032, 1'b0}, '{12'hfa0, 12'h032, 12'hf9f, 1'b0},
      '{12'h12c, 12'h12c, 12'h12c, 1'b0}};

   always #2 aclk = ~aclk;
   cam_output_controller #(.N_PROG(8), .MAX_SCALE(4096), .SPEED_WIN_CYC(64)) dut (.*);
   shaft_model shaft (.aclk(aclk), .load(load), .ld_val(ld_val), .step(step), .raw_pos(raw_pos));

   task summarize;
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Each ready is sampled a little after the edge, once the design has settled.
   task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tr, done;
      s_axi_bready <= w;
      s_axi_rready <= !w;
      if (w)
      begin
         s_axi_awaddr <= 32'(a);
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
      end
      else
      begin
         s_axi_araddr <= 32'(a);
         s_axi_arvalid <= 1'b1;
      end
      for (n = 0; n < 50; n++)
      begin
         #1;
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tr = s_axi_arvalid & s_axi_arready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         resp = w ? s_axi_bresp : s_axi_rresp;
         rd_val = s_axi_rdata;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         if (tr)
            s_axi_arvalid <= 1'b0;
         if (done)
            break;
      end
      if (n == 50)
      begin
         bad_count++;
         summarize;
      end
   endtask
   task win(input logic [31:0] s, input logic [11:0] on, off);
      bus(1, `CAM_REG_SEL, s);
      bus(1, `CAM_REG_ON, 32'(on));
      bus(1, `CAM_REG_OFF, 32'(off));
   endtask
   task put(input logic [11:0] r);
      load <= 1'b1;
      ld_val <= r;
      tick(1);
      load <= 1'b0;
      tick(8);
   endtask
   task pulse;
      mark_in <= 1'b1;
      tick(4);
      mark_in <= 1'b0;
      tick(4);
   endtask
   task trial(input logic mid);
      int n;
      put(12'h000);
      for (n = 0; n < 300 && cam_out[0] !== 1'b1; n++)
         tick(1);
      if (n == 300)
      begin
         bad_count++;
         summarize;
      end
      tick(100);
      check("timed mid", 32'(cam_out[0]), 32'(mid));
      tick(200);
      check("timed end", 32'(cam_out[0]), 32'h0);
   endtask

   initial
   begin
      tick(16);
      aresetn <= 1'b1;
      load <= 1'b0;
      tick(1);
      bus(0, `CAM_REG_SCALE, 0);
      check("scale reset", rd_val, 32'h0000_0168);
      bus(0, `CAM_REG_SPD_HI, 0);
      check("spd_hi reset", rd_val, 32'h0000_ffff);
      bus(1, 8'h54, 32'h1);
      check("unmapped", 32'(resp), 32'h2);
      bus(1, `CAM_REG_SCALE, 32'h400);
      put(12'h800);
      bus(0, `CAM_REG_POS, 0);
      check("pos scaled", 32'(rd_val[11:0]), 32'h200);
      bus(1, `CAM_REG_SCALE, 32'h0);
      bus(0, `CAM_REG_POS, 0);
      check("pos bad scale", 32'(rd_val[11:0]), 32'h200);
      bus(1, `CAM_REG_SCALE, 32'h1000);
      for (i = 0; i < 32; i++)
      begin
         win(32'((i / 16) * 256 + i % 16), 12'h000, 12'h000);
         bus(1, `CAM_REG_CHCFG, 32'h0);
      end
      bus(1, `CAM_REG_PROG, 32'h0);
      bus(1, `CAM_REG_GRPMODE, 32'h0);
      bus(1, `CAM_REG_SPD_LO, 32'h0);
      bus(1, `CAM_REG_CTRL, 32'h0);
      bus(1, `CAM_REG_IRQ_EN, 32'h0);
      for (i = 0; i < 9; i++)
      begin
         win(32'h0, rows[i].on, rows[i].off);
         put(rows[i].raw);
         check("cam window", 32'(cam_out[0]), 32'(rows[i].exp));
         bus(0, `CAM_REG_OUTS, 0);
         check("outs reg", 32'(rd_val[0]), 32'(rows[i].exp));
      end
      win(32'h100, 12'h00a, 12'h014);
      win(32'h0, 12'h064, 12'h0c8);
      put(12'h00f);
      check("prog 0", 32'(cam_out[0]), 32'h0);
      bus(1, `CAM_REG_PROG, 32'h1);
      tick(4);
      check("prog 1", 32'(cam_out[0]), 32'h1);
      bus(0, `CAM_REG_PROG, 0);
      check("prog read", rd_val, 32'h1);
      bus(1, `CAM_REG_PROG, 32'h0);
      prog_sel <= 3'h1;
      tick(4);
      check("pin prog", 32'(cam_out[0]), 32'h1);
      prog_sel <= 3'h0;
      put(12'h096);
      bus(1, `CAM_REG_GRPMODE, 32'h1);
      tick(4);
      check("group low", 32'(cam_out[0]), 32'h0);
      group_en <= 4'h1;
      tick(6);
      check("group high", 32'(cam_out[0]), 32'h1);
      bus(1, `CAM_REG_CTRL, 32'h1);
      put(12'h0a5);
      check("gray", 32'(cam_out[15:8]), 32'(8'ha5 ^ (8'ha5 >> 1)));
      bus(1, `CAM_REG_CTRL, 32'h0);
      bus(1, `CAM_REG_MARK, 32'h00c8_0064);
      put(12'h032);
      pulse;
      bus(0, `CAM_REG_IRQ_STAT, 0);
      check("early", 32'(rd_val[1:0]), 32'h1);
      check("masked", 32'(irq), 32'h0);
      bus(1, `CAM_REG_IRQ_EN, 32'h1);
      check("irq set", 32'(irq), 32'h1);
      bus(1, `CAM_REG_IRQ_CLR, 32'h7);
      check("irq clear", 32'(irq), 32'h0);
      put(12'h0fa);
      pulse;
      bus(0, `CAM_REG_IRQ_STAT, 0);
      check("late", 32'(rd_val[1:0]), 32'h2);
      bus(1, `CAM_REG_IRQ_EN, 32'h0);
      win(32'h0, 12'h001, 12'h000);
      bus(1, `CAM_REG_CHCFG, 32'h2);
      bus(1, `CAM_REG_SPD_LO, 32'ha);
      bus(1, `CAM_REG_ANA_ZERO, 32'h0);
      bus(1, `CAM_REG_ANA_FULL, 32'h80);
      put(12'h096);
      tick(200);
      check("stopped", 32'({motion_ok, cam_out[0]}), 32'h0);
      step <= 12'h001;
      tick(200);
      check("in range", 32'({motion_ok, cam_out[0]}), 32'h3);
      check("analog", 32'(analog_level), 32'h0000_7fff);
      bus(1, `CAM_REG_SPD_HI, 32'h14);
      tick(200);
      check("overspeed", 32'({motion_ok, cam_out[0]}), 32'h0);
      bus(1, `CAM_REG_SPD_HI, 32'hffff);
      bus(1, `CAM_REG_CHCFG, 32'h1a);
      tick(2);
      check("rev dir", 32'(cam_out[0]), 32'h0);
      bus(1, `CAM_REG_CHCFG, 32'h1);
      bus(1, `CAM_REG_TIMED, 32'h1);
      win(32'h0, 12'h064, 12'h3e8);
      trial(1'b1);
      win(32'h0, 12'h064, 12'h096);
      trial(1'b0);
      summarize;
   end
endmodule
